// ===== rtl/scs_pkg.sv
// package: register map, field layout and carriers of the system clock switching block
package scs_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] SCS_OFF_CTRL = 8'h00;
  localparam logic [7:0] SCS_OFF_STATUS = 8'h04;
  localparam logic [7:0] SCS_OFF_INT_STAT = 8'h08;
  localparam logic [7:0] SCS_OFF_INT_MASK = 8'h0c;
  localparam logic [7:0] SCS_OFF_LF_DIV = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // control register
  localparam int SCS_CTRL_XTAL_SEL = 0;
  localparam int SCS_CTRL_CPU_SEL = 1;
  localparam int SCS_CTRL_LF_DIGITAL = 2;
  // status register
  localparam int SCS_ST_SYS_SRC = 0;
  localparam int SCS_ST_CPU_SRC = 1;
  localparam int SCS_ST_FAILED = 2;
  localparam int SCS_ST_FLASH = 3;
  localparam int SCS_ST_SWITCHING = 4;
  // interrupt status and mask
  localparam int SCS_EV_FAILOVER = 0;
  localparam int SCS_EV_FLASH = 1;
  localparam int SCS_EV_SWITCHED = 2;
  localparam int SCS_EV_W = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SCS_CTRL_RST = 3'h0;
  localparam logic [SCS_EV_W-1:0] SCS_INT_MASK_RST = 3'h0;
  // divider in 4.12 fixed point: 10.0 turns 10 kHz into 1 kHz
  localparam logic [15:0] SCS_LF_DIV_RST = 16'ha000;
  localparam logic [15:0] SCS_LF_STEP = 16'h1000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SCS_CLK_MHZ = 100;
  // crystal counted as dead after this long without a level change
  localparam int SCS_XTAL_DEAD_NS = 200;
  localparam int SCS_XTAL_DEAD_CYC = (SCS_XTAL_DEAD_NS * SCS_CLK_MHZ) / 1000;
  localparam logic [7:0] SCS_XTAL_DEAD_CNT = 8'(SCS_XTAL_DEAD_CYC);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCS_SW_RUN = 2'b00,
    SCS_SW_PARK = 2'b01
  } scs_sw_state_t;

  typedef struct packed {
    logic hfRcOsc;
    logic hfXtalOsc;
    logic lfRcOsc;
    logic lfXtalOsc;
    logic lfOscSecondPin;
  } scs_osc_in_t;

  typedef struct packed {
    logic mainSystemClock;
    logic periphClock;
    logic cpuCoreClock;
    logic oneKhzReference;
    logic lfClock;
  } scs_clk_out_t;

endpackage

// ===== rtl/scs_system_clock_switching.sv
// system clock switching: source select, derived clocks, failover and APB registers
// Functional notes
// - reset selects internal 12 MHz RC source
// - crystal select bit picks RC or crystal
// - peripheral clock is half system clock
// - cpu select: 0 peripheral, 1 system clock
// - flash program/erase forces cpu clock 12 MHz
// - dead crystal fails over to RC source
// - failover raises non-maskable interrupt request
// - fractional divider makes 1 kHz from 10 kHz
// - second pin digital input replaces 32k crystal
// - crystal plus fast gives 24/12/24 MHz
`timescale 1ns/1ps
module scs_system_clock_switching
  import scs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire scs_osc_in_t oscIn,
  input wire logic flashBusy,
  output scs_clk_out_t clkOut,
  output logic irq,
  output logic nmiReq
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] syncA_reg;
  logic [4:0] syncB_reg;
  logic [4:0] syncC_reg;
  logic [4:0] oscF_reg;
  logic [4:0] agree;

  // a level is taken only once the second and third stage agree
  assign agree = syncB_reg ~^ syncC_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_reg <= 5'h00;
      syncB_reg <= 5'h00;
      syncC_reg <= 5'h00;
      oscF_reg <= 5'h00;
    end else if (ce) begin
      syncA_reg <= oscIn;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
      oscF_reg <= (oscF_reg & ~agree) | (syncC_reg & agree);
    end
  end

  logic hfRcS;
  logic xtalS;
  logic lfRcS;
  logic lfXtalS;
  logic lfPinS;
  assign {hfRcS, xtalS, lfRcS, lfXtalS, lfPinS} = oscF_reg;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [2:0] ctrl_reg;
  logic [SCS_EV_W-1:0] intStat_reg;
  logic [SCS_EV_W-1:0] intMask_reg;
  logic [15:0] lfDiv_reg;
  logic failed_reg;
  logic wrEn;
  logic rdEn;
  logic mapped;
  logic [SCS_EV_W-1:0] evSet;
  logic [SCS_EV_W-1:0] evClr;

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !penable && !pwrite;
  assign mapped = (paddr == SCS_OFF_CTRL) || (paddr == SCS_OFF_STATUS) ||
                  (paddr == SCS_OFF_INT_STAT) || (paddr == SCS_OFF_INT_MASK) ||
                  (paddr == SCS_OFF_LF_DIV);
  // zero wait states; error only in the access phase of an unmapped address
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= SCS_CTRL_RST;
      intMask_reg <= SCS_INT_MASK_RST;
      lfDiv_reg <= SCS_LF_DIV_RST;
    end else if (ce && wrEn) begin
      if (paddr == SCS_OFF_CTRL) begin
        ctrl_reg <= pwdata[2:0];
      end
      if (paddr == SCS_OFF_INT_MASK) begin
        intMask_reg <= pwdata[SCS_EV_W-1:0];
      end
      if (paddr == SCS_OFF_LF_DIV) begin
        lfDiv_reg <= pwdata[15:0];
      end
    end
  end

  assign evClr = (wrEn && paddr == SCS_OFF_INT_STAT) ? pwdata[SCS_EV_W-1:0] : 3'h0;

  // set wins over a simultaneous write-one clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      intStat_reg <= 3'h0;
    end else if (ce) begin
      intStat_reg <= (intStat_reg & ~evClr) | evSet;
    end
  end

  assign irq = |(intStat_reg & intMask_reg);

  // ----------------------------------------------------------------
  // crystal failure detection
  // ----------------------------------------------------------------
  logic [7:0] deadCnt_reg;
  logic xtalLast_reg;
  logic xtalDead;

  assign xtalDead = ctrl_reg[SCS_CTRL_XTAL_SEL] && !failed_reg &&
                    (deadCnt_reg >= SCS_XTAL_DEAD_CNT);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      deadCnt_reg <= 8'h00;
      xtalLast_reg <= 1'b0;
    end else if (ce) begin
      xtalLast_reg <= xtalS;
      if (!ctrl_reg[SCS_CTRL_XTAL_SEL] || failed_reg || xtalS != xtalLast_reg) begin
        deadCnt_reg <= 8'h00;
      end else if (deadCnt_reg != 8'hff) begin
        deadCnt_reg <= deadCnt_reg + 8'h01;
      end
    end
  end

  // latched until software clears the failover event
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      failed_reg <= 1'b0;
    end else if (ce) begin
      if (xtalDead) begin
        failed_reg <= 1'b1;
      end else if (evClr[SCS_EV_FAILOVER]) begin
        failed_reg <= 1'b0;
      end
    end
  end

  // not gated by the mask: held until the failover event is cleared
  assign nmiReq = intStat_reg[SCS_EV_FAILOVER];

  // ----------------------------------------------------------------
  // main system clock mux
  // ----------------------------------------------------------------
  scs_sw_state_t swState_reg;
  scs_sw_state_t swState_next;
  logic curSrc_reg;
  logic curSrc_next;
  logic wantSrc;
  logic srcLvl;
  logic main_system_clock_reg;
  logic main_system_clock_next;

  assign wantSrc = ctrl_reg[SCS_CTRL_XTAL_SEL] && !failed_reg && !xtalDead;
  assign srcLvl = curSrc_reg ? xtalS : hfRcS;

  // switch only after a full high phase or at once on a dead crystal; park low until the new source is low
  always_comb begin
    swState_next = swState_reg;
    curSrc_next = curSrc_reg;
    main_system_clock_next = srcLvl;
    case (swState_reg)
      SCS_SW_RUN: begin
        if (wantSrc != curSrc_reg && (!srcLvl || xtalDead)) begin
          curSrc_next = wantSrc;
          main_system_clock_next = 1'b0;
          swState_next = SCS_SW_PARK;
        end
      end
      SCS_SW_PARK: begin
        main_system_clock_next = 1'b0;
        if (!srcLvl) begin
          swState_next = SCS_SW_RUN;
        end
      end
      default: begin
        swState_next = SCS_SW_RUN;
        main_system_clock_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      swState_reg <= SCS_SW_RUN;
      curSrc_reg <= 1'b0;
      main_system_clock_reg <= 1'b0;
    end else if (ce) begin
      swState_reg <= swState_next;
      curSrc_reg <= curSrc_next;
      main_system_clock_reg <= main_system_clock_next;
    end
  end

  // ----------------------------------------------------------------
  // peripheral and cpu clocks
  // ----------------------------------------------------------------
  logic periph_reg;
  logic periph_next;
  logic cpuCur_reg;
  logic cpuWant;
  logic cpuClk_reg;
  logic flashLast_reg;

  // toggles on each system rise, so half rate in every mode
  assign periph_next = periph_reg ^ (main_system_clock_next && !main_system_clock_reg);

  // flash override: 12 MHz is the system clock on RC, the peripheral on crystal
  always_comb begin
    if (flashBusy) begin
      cpuWant = !curSrc_reg;
    end else begin
      cpuWant = ctrl_reg[SCS_CTRL_CPU_SEL];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      periph_reg <= 1'b0;
      cpuCur_reg <= 1'b0;
      cpuClk_reg <= 1'b0;
    end else if (ce) begin
      periph_reg <= periph_next;
      // both candidates low: the next high phase is a whole one
      if (cpuWant != cpuCur_reg && !main_system_clock_next && !periph_next) begin
        cpuCur_reg <= cpuWant;
        cpuClk_reg <= 1'b0;
      end else begin
        cpuClk_reg <= cpuCur_reg ? main_system_clock_next : periph_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // low-frequency clocks
  // ----------------------------------------------------------------
  logic [15:0] acc_reg;
  logic [16:0] accSum;
  logic lfRcLast_reg;
  logic oneKhz_reg;
  logic lfClk_reg;

  assign accSum = {1'b0, acc_reg} + {1'b0, SCS_LF_STEP};

  // phase accumulator; output high during the first half of each period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_reg <= 16'h0000;
      lfRcLast_reg <= 1'b0;
      oneKhz_reg <= 1'b0;
    end else if (ce) begin
      lfRcLast_reg <= lfRcS;
      if (lfRcS && !lfRcLast_reg) begin
        if (accSum >= {1'b0, lfDiv_reg}) begin
          acc_reg <= 16'(accSum - {1'b0, lfDiv_reg});
        end else begin
          acc_reg <= accSum[15:0];
        end
      end
      oneKhz_reg <= acc_reg < {1'b0, lfDiv_reg[15:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lfClk_reg <= 1'b0;
    end else if (ce) begin
      lfClk_reg <= ctrl_reg[SCS_CTRL_LF_DIGITAL] ? lfPinS : lfXtalS;
    end
  end

  assign clkOut = '{mainSystemClock: main_system_clock_reg, periphClock: periph_reg,
                    cpuCoreClock: cpuClk_reg, oneKhzReference: oneKhz_reg,
                    lfClock: lfClk_reg};

  // ----------------------------------------------------------------
  // events and read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flashLast_reg <= 1'b0;
    end else if (ce) begin
      flashLast_reg <= flashBusy;
    end
  end

  always_comb begin
    evSet = 3'h0;
    evSet[SCS_EV_FAILOVER] = xtalDead;
    evSet[SCS_EV_FLASH] = flashBusy && !flashLast_reg;
    evSet[SCS_EV_SWITCHED] = (swState_reg == SCS_SW_PARK) && (swState_next == SCS_SW_RUN);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (ce && rdEn) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        SCS_OFF_CTRL: prdata[2:0] <= ctrl_reg;
        SCS_OFF_STATUS: prdata[4:0] <= {swState_reg == SCS_SW_PARK, flashBusy, failed_reg,
                                        cpuCur_reg, curSrc_reg};
        SCS_OFF_INT_STAT: prdata[SCS_EV_W-1:0] <= intStat_reg;
        SCS_OFF_INT_MASK: prdata[SCS_EV_W-1:0] <= intMask_reg;
        SCS_OFF_LF_DIV: prdata[15:0] <= lfDiv_reg;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ===== tb/scs_far_model.sv
// partner model: oscillator sources and flash busy flag
`timescale 1ns/1ps
module scs_far_model
  import scs_pkg::*;
(
  input wire logic clk,
  input wire logic xtalStop,
  input wire logic flashReq,
  output scs_osc_in_t oscIn,
  output logic flashBusy
);
  logic [4:0] cntReg = 5'h00;
  logic xtalReg = 1'b0;
  always_ff @(posedge clk) begin
    cntReg <= cntReg + 5'h01;
    // a dead crystal stops on its last level
    xtalReg <= xtalStop ? xtalReg : cntReg[1];
    flashBusy <= flashReq;
  end
  // rc twice the crystal period, second pin twice the lf crystal rate
  assign oscIn = '{hfRcOsc: cntReg[2], hfXtalOsc: xtalReg, lfRcOsc: cntReg[3],
    lfXtalOsc: cntReg[4], lfOscSecondPin: cntReg[3]};
endmodule

// ===== tb/scs_props.sv
// checker: port-level properties of the clock switching block
`timescale 1ns/1ps
module scs_props
  import scs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire scs_clk_out_t clkOut,
  input wire logic irq,
  input wire logic nmiReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic hole;
  assign acc = psel && penable;
  assign hole = !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10});

  reset_outs_a: assert property (disable iff (1'b0) !rst_n && ce |=> clkOut == '0 && !nmiReq)
    else $error("outputs not cleared by reset");
  zero_wait_a: assert property (psel |-> pready)
    else $error("pready low during transfer");
  err_map_a: assert property (acc && hole |-> pslverr)
    else $error("unmapped access without error");
  err_only_a: assert property (pslverr |-> acc && hole)
    else $error("error outside unmapped access");
  hole_read_a: assert property (acc && !pwrite && hole |-> prdata == '0)
    else $error("unmapped read not zero");
  nmi_clear_a: assert property ($fell(nmiReq) |->
    $past(!rst_n) || $past(acc && ce && pwrite && paddr == 8'h08 && pwdata[0]))
    else $error("nmi request dropped without clear");
  sys_pulse_a: assert property ($rose(clkOut.mainSystemClock) && !nmiReq |=>
    clkOut.mainSystemClock || nmiReq)
    else $error("short system clock pulse");
  cpu_pulse_a: assert property ($rose(clkOut.cpuCoreClock) && !nmiReq |=>
    clkOut.cpuCoreClock || nmiReq)
    else $error("short cpu clock pulse");
  periph_half_a: assert property ($rose(clkOut.mainSystemClock) |->
    (##[0:2] $changed(clkOut.periphClock)) or ($past(clkOut.periphClock)
    != $past(clkOut.periphClock, 2)))
    else $error("peripheral clock missed a system rise");
  ce_hold_a: assert property (!ce |=> $stable(clkOut) && $stable(nmiReq))
    else $error("outputs moved while frozen");

  cover property ($rose(nmiReq));
  cover property ($rose(irq));
  cover property (!ce);
endmodule

bind scs_system_clock_switching scs_props i_scs_props (.clk, .rst_n, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .clkOut, .irq, .nmiReq);

// ===== tb/scs_system_clock_switching_tb_top.sv
// testbench: register sequences and clock rate checks
`timescale 1ns/1ps
module scs_system_clock_switching_tb_top
  import scs_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, nmiReq, flashBusy;
  logic xtalStop = 1'b0;
  logic flashReq = 1'b0;
  scs_osc_in_t oscIn;
  scs_clk_out_t clkOut;
  scs_clk_out_t prevOut;
  logic [31:0] q;
  logic err;
  int rises [5];
  int errorCnt = 0;
  int compares = 0;
  int cycles = 0;

  scs_system_clock_switching i_scs_system_clock_switching (.clk, .rst_n, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .oscIn, .flashBusy,
    .clkOut, .irq, .nmiReq);
  scs_far_model i_scs_far_model (.clk, .xtalStop, .flashReq, .oscIn, .flashBusy);

  initial forever #5 clk = ~clk;

  task automatic wrap_up();
    if (errorCnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errorCnt++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // counts are taken from a sampled replica, so allow two edges of slack
  task automatic near(input string what, input int n, input int e);
    chk(what, 32'((n > e - 3 && n < e + 3) ? e : n), 32'(e));
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic measure(input int n);
    rises = '{default: 0};
    prevOut = clkOut;
    repeat (n) begin
      @(posedge clk);
      for (int i = 0; i < 5; i++) if (clkOut[i] && !prevOut[i]) rises[i]++;
      prevOut = clkOut;
    end
  endtask

  task automatic mode(input logic [31:0] ctrl, input logic fl, input int s, input int c);
    flashReq <= fl;
    apb(1'b1, SCS_OFF_CTRL, ctrl);
    repeat (30) @(posedge clk);
    measure(400);
    near("main_system_clock", rises[4], s);
    near("periphClk", rises[3], s / 2);
    near("cpuClk", rises[2], c);
    apb(1'b0, SCS_OFF_STATUS, 32'h0);
    chk("flashBusy", q[3], fl);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("clkOut", 32'(clkOut), 32'h0);
    apb(1'b0, SCS_OFF_STATUS, 32'h0);
    chk("status", q, 32'h0);
    chk("statusErr", err, 1'b0);
    apb(1'b0, SCS_OFF_LF_DIV, 32'h0);
    chk("lfDiv", q, 32'(SCS_LF_DIV_RST));
    apb(1'b0, 8'h20, 32'h0);
    chk("hole", q, 32'h0);
    chk("holeErr", err, 1'b1);
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    measure(640);
    near("oneKhz", rises[1], 4);
    near("lfClk", rises[0], 20);
    apb(1'b1, SCS_OFF_CTRL, 32'h4);
    measure(640);
    near("lfPin", rises[0], 40);
    mode(32'h0, 1'b0, 50, 25);
    mode(32'h2, 1'b0, 50, 50);
    mode(32'h0, 1'b1, 50, 50);
    mode(32'h1, 1'b0, 100, 50);
    mode(32'h3, 1'b0, 100, 100);
    mode(32'h3, 1'b1, 100, 50);
    mode(32'h3, 1'b0, 100, 100);
    apb(1'b1, SCS_OFF_INT_STAT, 32'h7);
    xtalStop <= 1'b1;
    repeat (60) @(posedge clk);
    chk("nmiReq", nmiReq, 1'b1);
    chk("irqMasked", irq, 1'b0);
    apb(1'b0, SCS_OFF_STATUS, 32'h0);
    chk("statusFail", q[4:0], 5'h06);
    apb(1'b0, SCS_OFF_INT_STAT, 32'h0);
    chk("intStatFail", q, 32'h5);
    measure(400);
    near("sysFail", rises[4], 50);
    apb(1'b1, SCS_OFF_INT_MASK, 32'h1);
    chk("irqOn", irq, 1'b1);
    apb(1'b1, SCS_OFF_CTRL, 32'h0);
    apb(1'b1, SCS_OFF_INT_STAT, 32'h7);
    chk("nmiClr", nmiReq, 1'b0);
    chk("irqClr", irq, 1'b0);
    apb(1'b0, SCS_OFF_INT_STAT, 32'h0);
    chk("intStat", q, 32'h0);
    // ----------------------------------------------------------------
    // reset in mid-run with the crystal running
    // ----------------------------------------------------------------
    xtalStop <= 1'b0;
    apb(1'b1, SCS_OFF_CTRL, 32'h3);
    repeat (40) @(posedge clk);
    apb(1'b0, SCS_OFF_STATUS, 32'h0);
    chk("statusXtal", q[4:0], 5'h03);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("clkOutRst", 32'(clkOut), 32'h0);
    apb(1'b0, SCS_OFF_STATUS, 32'h0);
    chk("statusRst", q, 32'h0);
    wrap_up();
  end
endmodule
